// ==== shared/pscl_pkg.sv ====
package pscl_pkg;
   // Register file size and width
   localparam int REG_COUNT = 124;
   localparam int ADDR_W = 7;
   localparam int CH_COUNT = 8;
   // Register offsets
   localparam logic [6:0] REG_PAGE_ID = 7'h00;
   localparam logic [6:0] REG_CH_DIV_BASE = 7'h08;
   localparam logic [6:0] REG_CH_CFG_BASE = 7'h10;
   localparam logic [6:0] REG_STATUS0 = 7'h18;
   localparam logic [6:0] REG_STATUS1 = 7'h19;
   localparam logic [6:0] REG_INPUT_CFG = 7'h1a;
   localparam logic [6:0] REG_PRI_REF_DIV = 7'h1b;
   localparam logic [6:0] REG_FB_DIV_HI = 7'h1c;
   localparam logic [6:0] REG_FB_DIV_LO = 7'h1d;
   localparam logic [6:0] REG_PLL_REF_DIV = 7'h1e;
   localparam logic [6:0] REG_PLL_CTRL = 7'h1f;
   localparam logic [6:0] REG_LAST = 7'h7b;
   // Channel config fields, PLL power-down bit and status clock-mode bit
   localparam int CFG_FMT_LSB = 0;
   localparam int CFG_MUX_LSB = 2;
   localparam int CFG_MUTE_EN_BIT = 5;
   localparam int CFG_MUTE_LVL_LSB = 6;
   localparam logic [1:0] FMT_OFF = 2'h0;
   localparam logic [1:0] FMT_DIFF = 2'h1;
   localparam logic [1:0] FMT_CMOS = 2'h2;
   localparam int PLL_PD_BIT = 7;
   localparam int STATUS_CLK_MODE_BIT = 0;
   // Reset values
   localparam logic [7:0] REG_DEFAULT = 8'h00;
   localparam logic [7:0] CH_CFG_DEFAULT = 8'he1;
   // Strap levels and decode
   localparam logic [1:0] LVL_GND = 2'h0;
   localparam logic [1:0] LVL_MID = 2'h1;
   localparam logic [1:0] LVL_SUPPLY = 2'h2;
   localparam logic [3:0] COMBO_DEFAULTS = 4'h4;
   localparam logic [3:0] COMBO_FIRST_BAD = 4'h7;
   localparam logic [1:0] ROM_ADDR_LSB = 2'h0;
   // Positions in the synchronised pin bus
   localparam int PIN_ALIGN = 0;
   localparam int PIN_FREQ_TRIM_OFFSET_EN = 1;
   localparam int PIN_FREQ_TRIM_OFFSET_LSB = 2;
   localparam int PIN_ADDR_LSB = 5;
   localparam int PIN_PB_LSB = 7;
   localparam int PIN_PA_LSB = 9;
   localparam int PIN_STRAP_LSB = 11;
   localparam int PIN_PDN = 17;
   localparam int PIN_CSS = 18;
   localparam int PIN_COUNT = 19;

   typedef enum {ST_HOLD, ST_LATCH, ST_LOAD, ST_RUN} pscl_state_t;

   // Power-on value of one register
   function automatic logic [7:0] pscl_default(input int idx);
      if (idx >= int'(REG_CH_CFG_BASE) && idx < int'(REG_CH_CFG_BASE) + CH_COUNT) begin
         return CH_CFG_DEFAULT;
      end
      return REG_DEFAULT;
   endfunction
endpackage

// ==== src/pscl_loader.sv ====
// What this block does
// - Source select high: six two-level straps index one of 64 ROM pages.
// - ROM-page mode keeps host access and fixes address low bits at 00.
// - ROM-page mode aligns dividers at power-up and on each power-down pin cycle.
// - Invalid channel source mutes it per silence enable and level, defaults 1 and 3.
// - Muted differential output at level 3: positive leg high, negative leg low.
// - Muted CMOS output is held low.
// - Source select low: two three-level straps pick 6 pages, defaults, or invalid.
// - Both page straps floating: skip page load, keep register defaults.
// - Page mode: active-low align strap synchronises the outputs.
// - Page mode: address low bits 0, 1 or 3 from three-level strap.
// - Page mode: one strap enables trimming, another selects the trim offset.
// - Straps latch at power-on and on each power-down pin cycle, and stay until the next latch.
// - Each page carries an 8-bit identifier readable by software.
// - Loaded page sets an 8-bit divide value per channel.
// - Loaded page sets each channel's format, disable and mux selection.
// - Loaded page sets status pin mode, its divider and edge rate.
// - Loaded page sets input types, input mux mode and primary reference divider.
// - Loaded page sets PLL dividers, doubler, bandwidth and PLL power-down.
// - Register file holds 124 eight-bit registers from address zero.
// - Bits are named register number, period, bit position from zero.
// - Outputs stay disabled while in reset or initialising.
`timescale 1ns/1ps
module pscl_loader
   import pscl_pkg::*;
(
   input wire logic i_core_clk, // 20 MHz core clock
   input wire logic i_reset, // Power-on reset, active high
   input wire logic i_config_source_select, // High picks ROM pages
   input wire logic [5:0] i_strap_bits, // Two-level ROM page straps
   input wire logic [1:0] i_page_sel_a_lvl, // Three-level page strap A
   input wire logic [1:0] i_page_sel_b_lvl, // Three-level page strap B
   input wire logic [1:0] i_addr_strap_lvl, // Three-level address strap
   input wire logic i_freq_trim_enable, // Trim enable strap
   input wire logic [2:0] i_freq_trim_offset, // Eight-level trim offset strap
   input wire logic i_channel_align_low, // Output align, active low
   input wire logic i_powerdown_pin, // Low powers the device down
   input wire logic [CH_COUNT-1:0] i_ch_source_ok, // Mux source valid per channel
   input wire logic [7:0] i_mem_rdata, // Page memory read data
   input wire logic i_host_wr, // Host write strobe
   input wire logic i_host_rd, // Host read strobe
   input wire logic [ADDR_W-1:0] i_host_addr, // Host register address
   input wire logic [7:0] i_host_wdata, // Host write data
   output logic o_mem_rd, // Page memory read request
   output logic o_mem_eeprom, // High reads EEPROM, low ROM
   output logic [5:0] o_mem_page, // Page number
   output logic [ADDR_W-1:0] o_mem_addr, // Byte within the page
   output logic [7:0] o_host_rdata, // Host read data
   output logic o_host_ack, // Host access done pulse
   output logic o_load_done, // Register file ready
   output logic o_hard_mode, // ROM page mode latched
   output logic o_strap_invalid, // Page straps in a bad state
   output logic [1:0] o_dev_addr_lsb, // Two-wire address low bits
   output logic o_trim_enable, // Trim enabled
   output logic [2:0] o_trim_offset, // Trim offset
   output logic o_output_align, // Divider alignment request
   output logic [7:0] o_page_id, // Loaded page identifier
   output logic o_pll_powerdown, // PLL power-down control
   output logic [1:0] o_status_clk_mode, // Status pins in clock mode
   output logic [CH_COUNT-1:0] o_ch_enable, // Channel driver enabled
   output logic [CH_COUNT-1:0] o_ch_mute, // Channel muted
   output logic [CH_COUNT-1:0] o_ch_force_p, // Forced level, positive leg
   output logic [CH_COUNT-1:0] o_ch_force_n // Forced level, negative leg
);

   // Everything the loader remembers travels in one packed word.
   // The synchroniser stages sit here too, so reset clears them
   // together with the sequencer.
   typedef struct packed {
      // Two-stage pin synchroniser
      logic [PIN_COUNT-1:0] sync1;
      logic [PIN_COUNT-1:0] sync2;

      // Sequencer and latched strap results
      pscl_state_t st;
      logic hard_mode;
      logic strap_bad;
      logic [1:0] addr_lsb;
      logic trim_en;
      logic [2:0] trim_sel;

      // Page memory request
      logic mem_rd;
      logic mem_eeprom;
      logic [5:0] mem_page;
      logic [ADDR_W-1:0] mem_addr;

      // Host side
      logic [7:0] host_rdata;
      logic host_ack;
      logic load_done;

      // Register-derived outputs
      logic align;
      logic [7:0] page_id;
      logic pll_pd;
      logic [1:0] stat_clk;

      // Channel driver controls
      logic [CH_COUNT-1:0] ch_en;
      logic [CH_COUNT-1:0] ch_mute;
      logic [CH_COUNT-1:0] ch_p;
      logic [CH_COUNT-1:0] ch_n;

      // Register file, one byte per address
      logic [REG_COUNT-1:0][7:0] regs;
   } pscl_regs_t;

   // Current and next state
   pscl_regs_t s_q;
   pscl_regs_t s_d;

   // Combinational helpers
   logic [PIN_COUNT-1:0] pins;
   logic [CH_COUNT-1:0] en_w;
   logic [CH_COUNT-1:0] mute_w;
   logic [CH_COUNT-1:0] p_w;
   logic [CH_COUNT-1:0] n_w;

   // Clean power-on state with all registers at their defaults
   // Channel configs start with drivers on, mute enabled at level 3
   function automatic pscl_regs_t reset_state();
      pscl_regs_t r;
      r = '0;
      r.st = ST_HOLD;
      for (int k = 0; k < REG_COUNT; k++) begin
         r.regs[k] = pscl_default(k);
      end
      return r;
   endfunction

   // Three-level strap to 0, 1 or 2
   function automatic logic [3:0] lvl3(input logic [1:0] lvl);
      if (lvl == LVL_GND) begin
         return 4'h0;
      end
      if (lvl == LVL_MID) begin
         return 4'h1;
      end
      return 4'h2;
   endfunction

   // Address strap level to address low bits
   function automatic logic [1:0] addr_bits(input logic [1:0] lvl);
      if (lvl == LVL_GND) begin
         return 2'h0;
      end
      if (lvl == LVL_MID) begin
         return 2'h1;
      end
      return 2'h3;
   endfunction

   // All strap and control pins gathered for the synchroniser
   // The order must match the pin positions in the package
   assign pins = {i_config_source_select, i_powerdown_pin, i_strap_bits, i_page_sel_a_lvl,
                  i_page_sel_b_lvl, i_addr_strap_lvl, i_freq_trim_offset,
                  i_freq_trim_enable, i_channel_align_low};

   // Per-channel driver enable and auto-mute forcing
   // Driver controls are registered, so they trail their cause by one
   // cycle; the whole group moves together, so no leg glitches alone
   genvar gi;
   generate
      for (gi = 0; gi < CH_COUNT; gi++) begin : g_ch
         logic [7:0] cfg;
         logic [1:0] fmt;
         logic [1:0] lvl;
         assign cfg = s_q.regs[int'(REG_CH_CFG_BASE) + gi];
         assign fmt = cfg[CFG_FMT_LSB +: 2];
         assign lvl = cfg[CFG_MUTE_LVL_LSB +: 2];
         // Drivers only run once loading is over and the format is not off
         assign en_w[gi] = (s_q.st == ST_RUN) && (fmt != FMT_OFF);
         assign mute_w[gi] = en_w[gi] && cfg[CFG_MUTE_EN_BIT] && !i_ch_source_ok[gi];
         // Differential: level 3 drives positive to rail, negative to ground
         assign p_w[gi] = mute_w[gi] && (fmt == FMT_DIFF) && lvl[0];
         assign n_w[gi] = mute_w[gi] && (fmt == FMT_DIFF) && !lvl[1];
      end
   endgenerate

   // Next-state logic for the whole loader.
   // The two page straps form a base-three number: a times three plus b.
   // Combination 4 is both straps floating, 7 and 8 are the bad ones.
   // Strap and pin reads below use only the second synchroniser stage; host strobes are read directly.
   always_comb begin
      logic [3:0] combo;
      combo = lvl3(s_q.sync2[PIN_PA_LSB +: 2]) * 4'h3 + lvl3(s_q.sync2[PIN_PB_LSB +: 2]);
      s_d = s_q;
      s_d.sync1 = pins;
      s_d.sync2 = s_q.sync1;
      s_d.host_ack = 1'b0;
      s_d.align = 1'b0;
      case (s_q.st)
         ST_HOLD: begin
            // Powered down: outputs off, registers back to defaults
            s_d.load_done = 1'b0;
            s_d.mem_rd = 1'b0;
            for (int k = 0; k < REG_COUNT; k++) begin
               s_d.regs[k] = pscl_default(k);
            end
            if (s_q.sync2[PIN_PDN]) begin
               s_d.st = ST_LATCH;
            end
         end
         ST_LATCH: begin
            // Straps are captured only here, once per power-up
            s_d.hard_mode = s_q.sync2[PIN_CSS];
            s_d.strap_bad = 1'b0;
            if (s_q.sync2[PIN_CSS]) begin
               // ROM pages leave trim off and the address bits fixed
               s_d.mem_eeprom = 1'b0;
               s_d.mem_page = s_q.sync2[PIN_STRAP_LSB +: 6];
               s_d.addr_lsb = ROM_ADDR_LSB;
               s_d.trim_en = 1'b0;
               s_d.trim_sel = 3'h0;
               s_d.mem_rd = 1'b1;
               s_d.mem_addr = '0;
               s_d.st = ST_LOAD;
            end else begin
               // Page mode takes address, trim and page from the straps
               s_d.mem_eeprom = 1'b1;
               s_d.addr_lsb = addr_bits(s_q.sync2[PIN_ADDR_LSB +: 2]);
               s_d.trim_en = s_q.sync2[PIN_FREQ_TRIM_OFFSET_EN];
               s_d.trim_sel = s_q.sync2[PIN_FREQ_TRIM_OFFSET_LSB +: 3];
               if (combo == COMBO_DEFAULTS) begin
                  s_d.st = ST_RUN;
               end else if (combo >= COMBO_FIRST_BAD) begin
                  s_d.strap_bad = 1'b1;
                  s_d.st = ST_RUN;
               end else begin
                  // Pages 0..5 skip the defaults combination
                  if (combo > COMBO_DEFAULTS) begin
                     s_d.mem_page = {2'h0, combo - 4'h1};
                  end else begin
                     s_d.mem_page = {2'h0, combo};
                  end
                  s_d.mem_rd = 1'b1;
                  s_d.mem_addr = '0;
                  s_d.st = ST_LOAD;
               end
            end
         end
         ST_LOAD: begin
            // Copy the whole page into the register file, one byte a cycle
            // The memory answers in the same cycle, so no wait is needed;
            // host strobes seen meanwhile are dropped, not queued
            s_d.regs[s_q.mem_addr] = i_mem_rdata;
            if (s_q.mem_addr == REG_LAST) begin
               s_d.mem_rd = 1'b0;
               s_d.st = ST_RUN;
               s_d.align = s_q.hard_mode;
            end else begin
               s_d.mem_addr = s_q.mem_addr + 7'h1;
            end
         end
         ST_RUN: begin
            s_d.load_done = 1'b1;
            // Page mode aligns while the strap is held low
            if (!s_q.hard_mode) begin
               s_d.align = !s_q.sync2[PIN_ALIGN];
            end
            // Host access only after loading is complete
            // Writes win over reads when both strobes arrive together;
            // out-of-range writes are acknowledged but dropped
            if (i_host_wr) begin
               if (i_host_addr <= REG_LAST) begin
                  s_d.regs[i_host_addr] = i_host_wdata;
               end
               s_d.host_ack = 1'b1;
            end else if (i_host_rd) begin
               if (i_host_addr <= REG_LAST) begin
                  s_d.host_rdata = s_q.regs[i_host_addr];
               end else begin
                  s_d.host_rdata = 8'h00;
               end
               s_d.host_ack = 1'b1;
            end
         end
         default: begin
            // Unknown state falls back to the powered-down state
            s_d.st = ST_HOLD;
         end
      endcase
      // Power-down pin low restarts the whole power-up sequence
      // This override comes last so it beats every state's own choice,
      // and a load cut short never reaches the running state
      if (!s_q.sync2[PIN_PDN] && s_q.st != ST_HOLD) begin
         s_d.st = ST_HOLD;
         s_d.load_done = 1'b0;
         s_d.mem_rd = 1'b0;
      end
      // Register-derived outputs
      // The page identifier trails register 0 by one cycle
      s_d.page_id = s_q.regs[REG_PAGE_ID];
      s_d.pll_pd = s_q.regs[REG_PLL_CTRL][PLL_PD_BIT];
      s_d.stat_clk = {s_q.regs[REG_STATUS1][STATUS_CLK_MODE_BIT],
                      s_q.regs[REG_STATUS0][STATUS_CLK_MODE_BIT]};
      s_d.ch_en = en_w;
      s_d.ch_mute = mute_w;
      s_d.ch_p = p_w;
      s_d.ch_n = n_w;
   end

   // State register
   // Synchronous reset puts every field at its power-on value
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         s_q <= reset_state();
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register
   assign o_mem_rd = s_q.mem_rd;
   assign o_mem_eeprom = s_q.mem_eeprom;
   assign o_mem_page = s_q.mem_page;
   assign o_mem_addr = s_q.mem_addr;

   // Host interface
   assign o_host_rdata = s_q.host_rdata;
   assign o_host_ack = s_q.host_ack;

   // Latched strap results
   assign o_load_done = s_q.load_done;
   assign o_hard_mode = s_q.hard_mode;
   assign o_strap_invalid = s_q.strap_bad;
   assign o_dev_addr_lsb = s_q.addr_lsb;
   assign o_trim_enable = s_q.trim_en;
   assign o_trim_offset = s_q.trim_sel;

   // Alignment and register-derived outputs
   assign o_output_align = s_q.align;
   assign o_page_id = s_q.page_id;
   assign o_pll_powerdown = s_q.pll_pd;
   assign o_status_clk_mode = s_q.stat_clk;

   // Channel driver controls
   assign o_ch_enable = s_q.ch_en;
   assign o_ch_mute = s_q.ch_mute;
   assign o_ch_force_p = s_q.ch_p;
   assign o_ch_force_n = s_q.ch_n;

endmodule

// ==== bench/pscl_loader_properties.sv ====
`timescale 1ns/1ps
module pscl_loader_properties
   import pscl_pkg::*;
(
   input wire logic i_core_clk, // Core clock
   input wire logic i_reset, // Sync reset
   input wire logic i_host_wr, // Host write strobe
   input wire logic i_host_rd, // Host read strobe
   input wire logic [CH_COUNT-1:0] i_ch_source_ok, // Source valid
   input wire logic o_host_ack, // Host ack
   input wire logic o_load_done, // Load finished
   input wire logic o_hard_mode, // ROM page mode
   input wire logic o_strap_invalid, // Bad page straps
   input wire logic [1:0] o_dev_addr_lsb, // Address low bits
   input wire logic o_output_align, // Align request
   input wire logic o_mem_rd, // Memory read
   input wire logic [ADDR_W-1:0] o_mem_addr, // Memory address
   input wire logic [CH_COUNT-1:0] o_ch_enable, // Channel enable
   input wire logic [CH_COUNT-1:0] o_ch_mute // Channel mute
);
   // All checks run on the core clock and pause in reset
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_reset);
   a_ack_next: assert property (
      (i_host_wr || i_host_rd) && o_load_done |=> o_host_ack)
      else $error("host access not acknowledged");
   a_ack_cause: assert property (
      o_host_ack |-> o_load_done && $past(i_host_wr || i_host_rd))
      else $error("ack without accepted request");
   a_hard_addr: assert property (o_hard_mode |-> o_dev_addr_lsb == 2'h0)
      else $error("ROM mode address bits not zero");
   a_addr_code: assert property (o_dev_addr_lsb != 2'h2)
      else $error("illegal address low bits");
   a_load_start: assert property ($rose(o_mem_rd) |-> o_mem_addr == 7'h00)
      else $error("load does not start at zero");
   a_load_step: assert property (o_mem_rd && $past(o_mem_rd)
      |-> o_mem_addr == $past(o_mem_addr) + 7'h01)
      else $error("load address not sequential");
   a_load_end: assert property ($fell(o_mem_rd) |-> $past(o_mem_addr) == REG_LAST)
      else $error("load length wrong");
   a_invalid_idle: assert property (o_strap_invalid |-> !o_mem_rd)
      else $error("invalid straps started a load");
   a_load_quiet: assert property (o_mem_rd |-> o_ch_enable == 8'h00)
      else $error("outputs enabled during load");
   a_mute_cause: assert property (
      o_ch_mute == (o_ch_mute & ~$past(i_ch_source_ok) & o_ch_enable))
      else $error("mute without invalid source");
   a_align_pulse: assert property (
      o_hard_mode && o_output_align |=> !o_output_align)
      else $error("align pulse too long");
   a_strap_keep: assert property (o_load_done && $past(o_load_done)
      |-> $stable(o_dev_addr_lsb) && $stable(o_hard_mode))
      else $error("strap result changed while running");
endmodule
bind pscl_loader pscl_loader_properties u_props (.i_core_clk, .i_reset, .i_host_wr, .i_host_rd,
   .i_ch_source_ok, .o_host_ack, .o_load_done, .o_hard_mode, .o_strap_invalid, .o_dev_addr_lsb,
   .o_output_align, .o_mem_rd, .o_mem_addr, .o_ch_enable, .o_ch_mute);

// ==== bench/pscl_mem_model.sv ====
`timescale 1ns/1ps
module pscl_mem_model (
   input wire logic i_core_clk, // Core clock
   input wire logic i_mem_rd, // Read request
   input wire logic i_mem_eeprom, // EEPROM or ROM
   input wire logic [5:0] i_mem_page, // Page number
   input wire logic [6:0] i_mem_addr, // Byte in page
   output logic [7:0] o_mem_rdata // Read data
);
   logic [7:0] byte_now;
   logic [7:0] last_q = 8'h00;
   // Byte n of each page lands in register n; byte 0 names the page
   assign byte_now = {i_mem_eeprom, 1'b0, i_mem_page} + {1'b0, i_mem_addr};
   // Idle bus shows the inverse of the last byte, never a stale match
   always_ff @(posedge i_core_clk) begin
      if (i_mem_rd) last_q <= byte_now;
   end
   assign o_mem_rdata = i_mem_rd ? byte_now : ~last_q;
endmodule

// ==== bench/test_pscl_loader.sv ====
`timescale 1ns/1ps
module test_pscl_loader;
   import pscl_pkg::*;
   logic clk = 1'b0, rst = 1'b1, css = 1'b0, ten = 1'b0, aln = 1'b1, powerdown_pin = 1'b1;
   logic hwr = 1'b0, hrd = 1'b0, mrd, meep, hack, done, hard, inval, tren, align, pllpd;
   logic [5:0] strap = 6'h00, mpage;
   logic [1:0] pa = 2'h0, pb = 2'h0, adr = 2'h0, dlsb, stat;
   logic [2:0] toff = 3'h0, troff;
   logic [7:0] ok = 8'hff, hwd = 8'h00, mrdata, hrdata, pid, chmu, chp, chn, chen;
   logic [6:0] haddr = 7'h00, maddr;
   logic [15:0] rnd = 16'he448;
   logic seen_align;
   logic [8:0] expq[$];
   int failures = 0, total_checks = 0;
   pscl_loader dut (.i_core_clk(clk), .i_reset(rst), .i_config_source_select(css),
      .i_strap_bits(strap), .i_page_sel_a_lvl(pa), .i_page_sel_b_lvl(pb), .i_addr_strap_lvl(adr),
      .i_freq_trim_enable(ten), .i_freq_trim_offset(toff), .i_channel_align_low(aln),
      .i_powerdown_pin(powerdown_pin), .i_ch_source_ok(ok), .i_mem_rdata(mrdata), .i_host_wr(hwr),
      .i_host_rd(hrd), .i_host_addr(haddr), .i_host_wdata(hwd), .o_mem_rd(mrd),
      .o_mem_eeprom(meep), .o_mem_page(mpage), .o_mem_addr(maddr), .o_host_rdata(hrdata),
      .o_host_ack(hack), .o_load_done(done), .o_hard_mode(hard), .o_strap_invalid(inval),
      .o_dev_addr_lsb(dlsb), .o_trim_enable(tren), .o_trim_offset(troff),
      .o_output_align(align), .o_page_id(pid), .o_pll_powerdown(pllpd),
      .o_status_clk_mode(stat), .o_ch_enable(chen), .o_ch_mute(chmu), .o_ch_force_p(chp),
      .o_ch_force_n(chn));
   pscl_mem_model mem (.i_core_clk(clk), .i_mem_rd(mrd), .i_mem_eeprom(meep),
      .i_mem_page(mpage), .i_mem_addr(maddr), .o_mem_rdata(mrdata));
   // Clock generator, 50 ns period
   initial forever #25 clk = ~clk;
   function automatic logic [15:0] lfsr_next(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [7:0] mem_byte(logic e, logic [5:0] p, logic [6:0] a);
      return {e, 1'b0, p} + {1'b0, a};
   endfunction
   task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge clk);
   endtask
   // One host access; a read notes its expected data
   task automatic host(logic wr, logic [6:0] a, logic [7:0] d);
      @(posedge clk);
      hwr <= wr;
      hrd <= !wr;
      haddr <= a;
      hwd <= d;
      expq.push_back({!wr, d});
      @(posedge clk);
      hwr <= 1'b0;
      hrd <= 1'b0;
   endtask
   // Power down, try a write while held, power up and wait for the load
   task automatic powercycle();
      int n;
      tick(1);
      powerdown_pin <= 1'b0;
      tick(4);
      hwr <= 1'b1;
      haddr <= 7'h01;
      hwd <= 8'h5a;
      tick(1);
      hwr <= 1'b0;
      tick(2);
      powerdown_pin <= 1'b1;
      seen_align = 1'b0;
      for (n = 0; n < 400 && done !== 1'b1; n++) begin
         @(negedge clk);
         seen_align |= (align === 1'b1);
      end
      if (n == 400) begin
         failures++;
         tally_and_finish();
      end
   endtask
   // Each ack takes the oldest note; an unexpected ack is a mismatch
   always @(negedge clk) begin
      if (hack === 1'b1) begin
         if (expq.size() == 0) check("ack", 8'h01, 8'h00);
         else begin
            if (expq[0][8]) check("rdata", hrdata, expq[0][7:0]);
            void'(expq.pop_front());
         end
      end
   end
   initial begin
      int c;
      logic [5:0] pg;
      logic [7:0] ev;
      tick(12);
      rst <= 1'b0;
      // Let the power-on load finish before the first power cycle cuts it
      for (c = 0; c < 400 && done !== 1'b1; c++) tick(1);
      if (done !== 1'b1) failures++;
      // Every page strap combination, with address and trim straps
      for (c = 0; c < 9; c++) begin
         pa <= 2'(c / 3);
         pb <= 2'(c % 3);
         adr <= 2'(c % 3);
         rnd = lfsr_next(rnd);
         ten <= rnd[0];
         toff <= rnd[3:1];
         powercycle();
         pg = (c < 4) ? 6'(c) : 6'(c - 1);
         ev = (c == 4 || c > 6) ? 8'h00 : mem_byte(1'b1, pg, 7'h00);
         check("invalid", inval, 8'(c > 6));
         check("addr", dlsb, 8'((c % 3 == 2) ? 3 : c % 3));
         check("trim", {tren, troff}, {ten, toff});
         check("pageid", pid, ev);
         host(1'b0, REG_PAGE_ID, ev);
         host(1'b0, 7'h01, (ev == 8'h00) ? 8'h00 : mem_byte(1'b1, pg, 7'h01));
         host(1'b0, REG_CH_CFG_BASE,
            (ev == 8'h00) ? CH_CFG_DEFAULT : mem_byte(1'b1, pg, 7'h10));
      end
      // Straps moved while running change nothing; align strap works
      adr <= 2'h0;
      aln <= 1'b0;
      tick(4);
      @(negedge clk);
      check("latched", dlsb, 8'h03);
      check("align", align, 8'h01);
      host(1'b1, REG_CH_CFG_BASE, 8'he1);
      aln <= 1'b1;
      ok <= 8'hfe;
      host(1'b0, REG_CH_CFG_BASE, 8'he1);
      tick(2);
      @(negedge clk);
      check("mute", chmu, 8'h01);
      check("legs", {chp[0], chn[0]}, 8'h02);
      host(1'b1, REG_CH_CFG_BASE, 8'he2);
      host(1'b1, 7'h7c, 8'h77);
      host(1'b0, 7'h7c, 8'h00);
      host(1'b1, REG_PLL_CTRL, 8'h80);
      host(1'b1, REG_STATUS0, 8'h01);
      tick(2);
      @(negedge clk);
      check("cmos", {chmu[0], chp[0], chn[0]}, 8'h04);
      check("pllpd", pllpd, 8'h01);
      check("statmode", stat, 8'h01);
      check("chen", chen, 8'hff);
      // ROM page mode from random straps
      tick(1);
      ok <= 8'hff;
      css <= 1'b1;
      rnd = lfsr_next(rnd);
      pg = rnd[5:0];
      strap <= pg;
      for (c = 0; c < 2; c++) begin
         powercycle();
         check("hard", {hard, dlsb, tren, troff}, 8'h40);
         check("sync", seen_align, 8'h01);
         host(1'b0, REG_PAGE_ID, mem_byte(1'b0, pg, 7'h00));
         host(1'b0, REG_LAST, mem_byte(1'b0, pg, REG_LAST));
         host(1'b0, 7'h01, mem_byte(1'b0, pg, 7'h01));
      end
      for (c = 0; c < 20 && expq.size() > 0; c++) tick(1);
      if (expq.size() > 0) failures++;
      tally_and_finish();
   end
endmodule
